// ### hdl/ccs_exec.sv
`timescale 1ns/1ps
module ccs_exec
   import ccs_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic [15:0] I_OPCODE,
   input wire logic I_NEXT_TWO_WORD,
   input wire logic [7:0] I_WREG,
   input wire logic [3:0] I_BANK_SELECT_REGISTER,
   input wire logic I_EXT_SET_EN,
   input wire logic [7:0] I_RD_DATA,
   output logic [11:0] O_ADDR,
   output logic O_ILO_MODE,
   output logic [7:0] O_ILO_OFFSET,
   output logic O_RD_EN,
   output logic O_MEM_WR,
   output logic [7:0] O_WR_DATA,
   output logic O_WREG_WR,
   output logic O_FLAG_WR,
   output logic O_FLAG_N,
   output logic O_FLAG_Z,
   output logic O_FETCH_EN,
   output logic O_SKIP_NOP,
   output logic [1:0] O_PHASE
);
   // ***********************
   // Decode.
   // ***********************
   ccs_phase_t phase;
   logic [7:0] hi;
   logic [7:0] fld;
   logic is_cmpl;
   logic is_cpeq;
   logic use_ilo;
   logic [11:0] dir_addr;
   logic [1:0] skip_q;
   logic [1:0] skip_d;
   logic [7:0] data_q;
   logic [7:0] res;
   logic instr_q;
   logic cmpl_q;
   logic dest_q;
   logic eq_q;

   ccs_qphase u_qphase (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .o_phase(phase)
   );

   assign hi = I_OPCODE[15:8];
   assign fld = I_OPCODE[7:0];
   // A pending skip blanks the decode, so the discarded word causes no read strobe, write or flag update.
   assign is_cmpl = (skip_q == 2'h0) && ((hi & CCS_CMPL_MASK) == CCS_CMPL_HI);
   assign is_cpeq = (skip_q == 2'h0) && ((hi & CCS_CPEQ_MASK) == CCS_CPEQ_HI);
   // Indexed mode hands the offset to the pointer logic outside this block.
   assign use_ilo = !I_OPCODE[CCS_BIT_A] && I_EXT_SET_EN && (fld <= CCS_ILO_LIMIT);
   assign dir_addr = I_OPCODE[CCS_BIT_A] ? {I_BANK_SELECT_REGISTER, fld}
                   : (fld >= CCS_ACC_HI_BASE) ? {CCS_ACC_HI_BANK, fld} : {4'h0, fld};
   assign res = ~data_q;
   assign skip_d = I_NEXT_TWO_WORD ? 2'h2 : 2'h1;

   // ***********************
   // Quarter phase datapath.
   // ***********************
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         instr_q <= 1'b0;
         cmpl_q <= 1'b0;
         dest_q <= 1'b0;
         eq_q <= 1'b0;
         data_q <= CCS_RST_BYTE;
         skip_q <= 2'h0;
         O_ADDR <= 12'h000;
         O_ILO_MODE <= 1'b0;
         O_ILO_OFFSET <= CCS_RST_BYTE;
         O_RD_EN <= 1'b0;
         O_MEM_WR <= 1'b0;
         O_WR_DATA <= CCS_RST_BYTE;
         O_WREG_WR <= 1'b0;
         O_FLAG_WR <= 1'b0;
         O_FLAG_N <= 1'b0;
         O_FLAG_Z <= 1'b0;
         O_FETCH_EN <= 1'b0;
         O_SKIP_NOP <= 1'b0;
         O_PHASE <= 2'h0;
      end else begin
         O_PHASE <= phase;
         O_RD_EN <= 1'b0;
         O_MEM_WR <= 1'b0;
         O_WREG_WR <= 1'b0;
         O_FLAG_WR <= 1'b0;
         O_FETCH_EN <= 1'b0;
         case (phase)
            CCS_Q1: begin
               instr_q <= is_cmpl || is_cpeq;
               cmpl_q <= is_cmpl;
               dest_q <= I_OPCODE[CCS_BIT_D];
               O_SKIP_NOP <= (skip_q != 2'h0);
               O_ADDR <= dir_addr;
               O_ILO_MODE <= use_ilo;
               O_ILO_OFFSET <= fld;
            end
            CCS_Q2: begin
               O_RD_EN <= instr_q;
               data_q <= I_RD_DATA;
            end
            CCS_Q3: begin
               // Unsigned subtract reduces to equality for this skip test.
               eq_q <= !cmpl_q && instr_q && (data_q == I_WREG);
               O_WR_DATA <= res;
            end
            CCS_Q4: begin
               O_FETCH_EN <= 1'b1;
               if (cmpl_q) begin
                  O_MEM_WR <= dest_q;
                  O_WREG_WR <= !dest_q;
                  O_FLAG_WR <= 1'b1;
                  O_FLAG_N <= res[7];
                  O_FLAG_Z <= (res == 8'h00);
               end
               // Compare never writes in phase four and leaves flags alone.
               if (eq_q) begin
                  skip_q <= skip_d;
               end else if (skip_q != 2'h0) begin
                  skip_q <= skip_q - 2'h1;
               end
               instr_q <= 1'b0;
               cmpl_q <= 1'b0;
               eq_q <= 1'b0;
            end
            default: instr_q <= 1'b0;
         endcase
      end
   end

   // ***********************
   // Assertions.
   // ***********************
   a_cmp_no_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q4 && !cmpl_q) |=> !O_MEM_WR && !O_WREG_WR && !O_FLAG_WR)
      else $error("compare wrote in phase four");
   a_dest_select: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q4 && cmpl_q) |=> (O_MEM_WR == dest_q) && (O_WREG_WR != O_MEM_WR))
      else $error("wrong destination");
   a_comp_value: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      O_FLAG_WR |-> (O_FLAG_Z == (O_WR_DATA == 8'h00)) && (O_FLAG_N == O_WR_DATA[7]))
      else $error("flags disagree with result");
   a_skip_nop_one: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q4 && eq_q && !I_NEXT_TWO_WORD) |=> ##1 O_SKIP_NOP ##4 !O_SKIP_NOP)
      else $error("single skip length wrong");
   a_skip_nop_two: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q4 && eq_q && I_NEXT_TWO_WORD) |=> ##1 O_SKIP_NOP ##4 O_SKIP_NOP ##4 !O_SKIP_NOP)
      else $error("double skip length wrong");
   a_nop_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      O_SKIP_NOP |-> !O_MEM_WR && !O_WREG_WR && !O_RD_EN)
      else $error("skipped cycle acted");
   a_bank_addr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && I_OPCODE[CCS_BIT_A]) |=> O_ADDR[11:8] == $past(I_BANK_SELECT_REGISTER))
      else $error("bank address wrong");
   a_ilo_mode: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1) |=> O_ILO_MODE == $past(use_ilo))
      else $error("indexed mode wrong");
   a_one_cycle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && is_cmpl) |=> ##3 O_FLAG_WR)
      else $error("complement not done in one cycle");

   // ***********************
   // Skip run guard.
   // ***********************
   // Counts edges spent in forced no-operation cycles, so the skip length is bounded without a long repetition.
   logic [3:0] skip_run_q;
   logic [3:0] skip_run_d;

   assign skip_run_d = O_SKIP_NOP ? (skip_run_q + 4'h1) : 4'h0;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         skip_run_q <= 4'h0;
      end else begin
         skip_run_q <= skip_run_d;
      end
   end

   // Checks below look one edge after the phase that launches each registered output.
   a_rd_strobe: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q2) |=> (O_RD_EN == $past(instr_q)))
      else $error("read strobe wrong");
   a_fetch_in_q4: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q4) |=> O_FETCH_EN)
      else $error("fetch missing after phase four");
   a_fetch_off: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase != CCS_Q4) |=> !O_FETCH_EN)
      else $error("fetch outside phase four");
   a_cmp_flags_kept: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && is_cpeq) |=> ##3 !O_FLAG_WR && !O_MEM_WR && !O_WREG_WR)
      else $error("compare touched flags or memory");
   a_skip_ignores: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && skip_q != 2'h0) |=> ##3 !O_FLAG_WR && !O_MEM_WR && !O_WREG_WR)
      else $error("discarded word executed");
   a_ilo_offset: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1) |=> (O_ILO_OFFSET == $past(fld)))
      else $error("indexed offset wrong");
   a_access_low: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && !I_OPCODE[CCS_BIT_A] && fld < CCS_ACC_HI_BASE)
      |=> (O_ADDR == {4'h0, $past(fld)}))
      else $error("low access bank address wrong");
   a_access_high: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q1 && !I_OPCODE[CCS_BIT_A] && fld >= CCS_ACC_HI_BASE)
      |=> (O_ADDR == {CCS_ACC_HI_BANK, $past(fld)}))
      else $error("high access bank address wrong");
   a_result_inv: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (phase == CCS_Q3 && instr_q) |=> (O_WR_DATA == ~$past(data_q)))
      else $error("result is not the inverted byte");
   a_skip_bound: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      skip_run_q <= CCS_SKIP_EDGES_MAX)
      else $error("skip ran too long");

   c_cmpl_mem: cover property (@(posedge I_CLK_SYS) O_FLAG_WR && O_MEM_WR);
   c_skip1: cover property (@(posedge I_CLK_SYS) phase == CCS_Q4 && eq_q && !I_NEXT_TWO_WORD);
   c_skip2: cover property (@(posedge I_CLK_SYS) phase == CCS_Q4 && eq_q && I_NEXT_TWO_WORD);
   c_ilo: cover property (@(posedge I_CLK_SYS) O_ILO_MODE && O_RD_EN);
   c_cmp_ne: cover property (@(posedge I_CLK_SYS) phase == CCS_Q4 && instr_q && !cmpl_q && !eq_q);
endmodule

// ### hdl/ccs_pkg.sv
// Functional notes
// - Opcode 0001 11da ffff ffff complements the byte; N and Z follow result.
// - Destination bit 0 writes working register; 1 writes back to the source.
// - Access bit 0 uses access bank; 1 uses bank select register for bank.
// - Access bit 0, extended set on, field up to 95 uses indexed literal offset.
// - Complement is one word, one cycle: decode, read, process, write destination.
// - Opcode 0110 001a ffff ffff compares byte with working register; no flags change.
// - On equality the fetched next instruction is discarded; two cycles in total.
// - Skipping a two-word instruction takes three cycles; added cycles do nothing.
// - Non-skipping compare cycle: decode, read, process, then no write in phase four.
package ccs_pkg;
   localparam logic [7:0] CCS_CMPL_HI = 8'h1C;
   localparam logic [7:0] CCS_CMPL_MASK = 8'hFC;
   localparam logic [7:0] CCS_CPEQ_HI = 8'h62;
   localparam logic [7:0] CCS_CPEQ_MASK = 8'hFE;
   localparam int CCS_BIT_D = 9;
   localparam int CCS_BIT_A = 8;
   localparam logic [7:0] CCS_ILO_LIMIT = 8'h5F;
   localparam logic [7:0] CCS_ACC_HI_BASE = 8'h60;
   localparam logic [3:0] CCS_ACC_HI_BANK = 4'hF;
   localparam logic [7:0] CCS_RST_BYTE = 8'h00;
   localparam logic [3:0] CCS_SKIP_EDGES_MAX = 4'h8;
   typedef enum logic [1:0] {
      CCS_Q1 = 2'b00,
      CCS_Q2 = 2'b01,
      CCS_Q3 = 2'b10,
      CCS_Q4 = 2'b11
   } ccs_phase_t;
endpackage

// ### hdl/ccs_qphase.sv
`timescale 1ns/1ps
module ccs_qphase
   import ccs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   output ccs_phase_t o_phase
);
   // ***********************
   // Quarter phase counter.
   // ***********************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_phase <= CCS_Q1;
      end else begin
         case (o_phase)
            CCS_Q1: o_phase <= CCS_Q2;
            CCS_Q2: o_phase <= CCS_Q3;
            CCS_Q3: o_phase <= CCS_Q4;
            CCS_Q4: o_phase <= CCS_Q1;
            default: o_phase <= CCS_Q1;
         endcase
      end
   end
endmodule

// ### verification/complement_and_compare_skip_exec_tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench for the complement and compare-skip unit.
// ****************************************
module complement_and_compare_skip_exec_tb;
   import ccs_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, two = 1'b0, ext = 1'b0;
   logic [15:0] opc = 16'h0000;
   logic [7:0] w = 8'h00, rd = 8'h00, dat, off, s_dat, e_off, x_off;
   logic [3:0] bank = 4'h0;
   logic [11:0] addr, e_addr, x_addr;
   logic [1:0] ph, e_ph;
   logic ilo, rden, mw, ww, fw, fn, fz, fe, skn, s_mw, s_ww, s_fw, s_fn, s_fz, skip_seen, s_rd, e_ilo, x_ilo;
   int bad_count = 0, checks_done = 0, n_fe = 0;
   ccs_exec u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_OPCODE(opc), .I_NEXT_TWO_WORD(two),
      .I_WREG(w), .I_BANK_SELECT_REGISTER(bank), .I_EXT_SET_EN(ext), .I_RD_DATA(rd),
      .O_ADDR(addr), .O_ILO_MODE(ilo), .O_ILO_OFFSET(off), .O_RD_EN(rden), .O_MEM_WR(mw),
      .O_WR_DATA(dat), .O_WREG_WR(ww), .O_FLAG_WR(fw), .O_FLAG_N(fn), .O_FLAG_Z(fz),
      .O_FETCH_EN(fe), .O_SKIP_NOP(skn), .O_PHASE(ph));
   initial begin
      forever #20 clk = ~clk;
   end
   // Pulses are gathered from each clear across every slot of an exec and after, so a one-edge shift in their timing is tolerated.
   always @(posedge clk) begin
      #1;
      s_mw |= mw;
      s_ww |= ww;
      s_fw |= fw;
      s_rd |= rden;
      n_fe += fe;
      if (mw | ww | fw) begin
         s_dat = dat;
         s_fn = fn;
         s_fz = fz;
      end
   end
   task automatic chk(input string nm, input logic [11:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic issue(input logic [15:0] op, input logic [7:0] r, wv, input logic [3:0] b, input logic e, t);
      @(negedge clk);
      {opc, rd, w, bank, ext, two} = {op, r, wv, b, e, t};
      repeat (3) @(posedge clk);
      #1;
      skip_seen = skn;
      {e_addr, e_ilo, e_off, e_ph} = {addr, ilo, off, ph};
      @(posedge clk);
   endtask
   task automatic exec(input logic [15:0] op, fol, input logic [7:0] r, wv, input logic [3:0] b, input logic e, t);
      // The clear waits past the collector's look at the last edge, so the previous slot stays out.
      #2;
      {s_mw, s_ww, s_fw, s_rd} = 4'h0;
      n_fe = 0;
      issue(op, r, wv, b, e, t);
      {x_addr, x_ilo, x_off} = {e_addr, e_ilo, e_off};
      chk("phase", 12'h002, 12'(e_ph));
      issue(fol, r, wv, b, e, t);
   endtask
   task automatic t_cmpl_mem;
      exec(16'h1F45, 16'h0000, 8'h13, 8'h00, 4'h3, 1'b1, 1'b0);
      chk("addr", 12'h345, x_addr);
      chk("mem_wr", 12'h001, 12'(s_mw));
      chk("wreg_wr", 12'h000, 12'(s_ww));
      chk("data", 12'h0EC, 12'(s_dat));
      chk("flags", 12'h006, {9'h0, s_fw, s_fn, s_fz});
      chk("rd_en", 12'h001, 12'(s_rd));
      chk("fetch", 12'h001, 12'(n_fe));
   endtask
   task automatic t_cmpl_w;
      exec(16'h1C80, 16'h0000, 8'hFF, 8'h00, 4'h3, 1'b1, 1'b0);
      chk("addr", 12'hF80, x_addr);
      chk("wr", 12'h002, {10'h0, s_ww, s_mw});
      chk("data", 12'h000, 12'(s_dat));
      chk("flags", 12'h005, {9'h0, s_fw, s_fn, s_fz});
   endtask
   task automatic t_ilo;
      exec(16'h1E5F, 16'h0000, 8'h00, 8'h00, 4'h3, 1'b1, 1'b0);
      chk("ilo", 12'h15F, {3'h0, x_ilo, x_off});
      exec(16'h1E60, 16'h0000, 8'h00, 8'h00, 4'h3, 1'b1, 1'b0);
      chk("ilo", 12'h000, 12'(x_ilo));
      exec(16'h1E20, 16'h0000, 8'h00, 8'h00, 4'h3, 1'b0, 1'b0);
      chk("addr", 12'h020, x_addr);
      chk("ilo", 12'h000, 12'(x_ilo));
   endtask
   task automatic t_cmp_ne;
      exec(16'h6345, 16'h0000, 8'h10, 8'h11, 4'h2, 1'b0, 1'b0);
      chk("addr", 12'h245, x_addr);
      chk("writes", 12'h000, {9'h0, s_mw, s_ww, s_fw});
      chk("rd_en", 12'h001, 12'(s_rd));
      chk("fetch", 12'h001, 12'(n_fe));
      chk("skip", 12'h000, 12'(skip_seen));
   endtask
   task automatic t_cmp_eq(input logic t);
      exec(16'h6210, 16'h1F10, 8'h5A, 8'h5A, 4'h2, 1'b0, t);
      chk("skip", 12'h001, 12'(skip_seen));
      issue(16'h0000, 8'h5A, 8'h00, 4'h2, 1'b0, 1'b0);
      chk("skip", 12'(t), 12'(skip_seen));
      chk("writes", 12'h000, {9'h0, s_mw, s_ww, s_fw});
      if (t) begin
         issue(16'h0000, 8'h5A, 8'h00, 4'h2, 1'b0, 1'b0);
         chk("skip", 12'h000, 12'(skip_seen));
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      // The first edge after release is a decode edge, so the slot grid starts there.
      repeat (4) @(posedge clk);
      #1;
      chk("idle", 12'h000, {9'h0, mw, ww, skn});
      t_cmpl_mem();
      t_cmpl_w();
      t_ilo();
      t_cmp_ne();
      t_cmp_eq(1'b0);
      t_cmp_eq(1'b1);
      tally_and_finish();
   end
endmodule
